// File: design/scs_sequencer.sv
// Successive-approximation conversion sequencer with an AXI4-Lite register port.
`timescale 1ns/1ps

// Summary of operation
// R1 - A 12-bit approximation register drives parallel outputs and feedback inputs directly.
// R2 - Bits are trialled one at a time, MSB first, kept or rejected by comparator.
// R3 - A trigger sets busy and releases the gated clock for 13 cycles.
// R4 - Trigger rise initialises register and busy; trigger fall releases the clock.
// R5 - First clock step drives bit 1 low and bits 2 to 12 high.
// R6 - Step n records bit n decision and drives bit n+1 low, ending at 12.
// R7 - Busy clears 40 ns after the final decision, marking valid output.
// R8 - Clearing busy holds the clock output low until the next conversion.
// R9 - Serial and parallel bits change on the same rising edge; stable at falls.
// R10 - Parallel and serial results are complemented.
// R11 - Parallel output gives offset binary, inverted MSB output gives two's complement.
// R12 - Serial coding is complemented straight or offset binary.
// R13 - Serial output sends one NRZ bit per clock cycle, MSB first.
// R14 - Serial data is valid within 200 ns of each rising clock edge.
// R15 - A full conversion produces exactly 13 falling clock edges.
// R16 - The receiver shifts on falling edges; its first shifted bit is invalid.
// R17 - An active short-cycle input ends conversion after bits so far.
// R18 - Short-cycle fed from bit 11 gives 10 bits; busy clears 40 ns after bit 10.
// R19 - Short-cycle held high gives a full 12-bit conversion.
// R20 - Conversion time stays within 25, 21 and 17 microseconds.
// R21 - The host may latch parallel data on the falling edge of busy.
// R22 - With a continuous external clock the host synchronises the trigger.
// R23 - Comparator is a synchronous input sampled at each decision; high keeps.

module scs_sequencer (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Register port.
    input wire scs_pkg::scs_axi_req_t axi_req,
    output scs_pkg::scs_axi_rsp_t axi_rsp,
    // Converter inputs.
    input wire logic convert_start,
    input wire logic comparator,
    input wire logic short_cycle_n,
    // Converter outputs.
    output scs_pkg::scs_pins_t pins
);
    import scs_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        scs_state_t state;
        logic [8:0] cnt;
        logic [3:0] step;
        logic [2:0] trig_sync;
        logic trig_lvl;
        logic [2:0] short_sync;
        logic short_lvl;
        scs_pins_t pins;
        logic [`SCS_NBITS-1:0] result;
        logic [3:0] result_bits;
        logic done;
        logic pin_en;
        logic sw_start;
        logic aw_got;
        logic [`SCS_ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        scs_axi_rsp_t rsp;
    } scs_regs_t;

    scs_regs_t s;
    scs_regs_t next_s;

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------

    // Computes the whole next state of the block.
    always_comb begin
        logic trig_rise;
        logic trig_fall;
        logic start_now;
        logic wr_fire;
        logic rd_fire;
        logic [3:0] idx;
        trig_rise = 1'b0;
        trig_fall = 1'b0;
        start_now = 1'b0;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        idx = 4'h0;
        next_s = s;

        // Pin inputs pass three flops; a level counts once stages two and three agree.
        next_s.trig_sync = {s.trig_sync[1:0], convert_start};
        next_s.short_sync = {s.short_sync[1:0], short_cycle_n};
        if (s.trig_sync[1] == s.trig_sync[2]) begin
            next_s.trig_lvl = s.trig_sync[2];
            trig_rise = s.trig_sync[2] && !s.trig_lvl && s.pin_en;
            trig_fall = !s.trig_sync[2] && s.trig_lvl;
        end
        if (s.short_sync[1] == s.short_sync[2]) begin
            next_s.short_lvl = s.short_sync[2];
        end

        // A software start behaves as a trigger pulse whose trailing edge is immediate.
        next_s.sw_start = 1'b0;
        start_now = trig_rise || s.sw_start;

        // Sequencer.
        case (s.state)
            SCS_IDLE, SCS_ARMED, SCS_CLK_LOW: begin
                if (s.state == SCS_ARMED && trig_fall) begin
                    next_s.state = SCS_CLK_LOW; // R4
                    next_s.cnt = 9'h000;
                end else if (s.state == SCS_CLK_LOW) begin
                    next_s.cnt = s.cnt + 9'h001;
                    // The half period sets the whole conversion time. Twelve and a half
                    // periods plus the status delay must stay inside the longest
                    // allowed conversion, so a half period above 998.4 ns breaks the
                    // timing budget even though every bit still comes out right.
                    if (s.cnt == 9'(`SCS_HALF_CYC - 1)) begin // R20
                        // Rising edge of the gated clock: t0 to t12.
                        next_s.state = SCS_CLK_HIGH;
                        next_s.cnt = 9'h000;
                        next_s.pins.bit_clk = 1'b1;
                        if (s.step == 4'h0) begin
                            // Complemented MSB trial value.
                            next_s.pins.approx_register = {1'b0, {(`SCS_NBITS-1){1'b1}}}; // R5
                            next_s.pins.msb_inv = 1'b1; // R11
                        end else begin
                            idx = 4'(`SCS_NBITS) - s.step;
                            // High comparator keeps the trial bit, which reads low.
                            next_s.pins.approx_register[idx] = !comparator; // R2 R23 R10
                            next_s.pins.serial = !comparator; // R9 R13 R12
                            if (s.step < 4'(`SCS_LAST_STEP)) begin
                                next_s.pins.approx_register[idx - 4'h1] = 1'b0; // R6
                            end
                            if (s.step == 4'h1) begin
                                next_s.pins.msb_inv = comparator; // R11
                            end
                        end
                    end
                end
            end
            SCS_CLK_HIGH: begin
                next_s.cnt = s.cnt + 9'h001;
                if (s.cnt == 9'(`SCS_STATUS_CYC - 1) && (s.step == 4'(`SCS_LAST_STEP)
                        || (s.step != 4'h0 && !s.short_lvl))) begin
                    // End of conversion: busy drops and the clock is forced low.
                    next_s.state = SCS_IDLE; // R7 R17 R18 R19
                    next_s.pins.busy = 1'b0; // R21
                    next_s.pins.bit_clk = 1'b0; // R8 R15
                    next_s.result = s.pins.approx_register;
                    next_s.result_bits = s.step;
                    next_s.done = 1'b1;
                end else if (s.cnt == 9'(`SCS_HALF_CYC - 1)) begin
                    // Falling edge of the gated clock; serial data holds across it.
                    next_s.state = SCS_CLK_LOW; // R3 R16
                    next_s.cnt = 9'h000;
                    next_s.pins.bit_clk = 1'b0;
                    next_s.step = s.step + 4'h1;
                end
            end
            default: begin
                next_s.state = SCS_IDLE;
            end
        endcase

        // A trigger restarts the sequence from any state.
        if (start_now) begin
            next_s.state = s.sw_start ? SCS_CLK_LOW : SCS_ARMED; // R3 R4
            next_s.cnt = 9'h000;
            next_s.step = 4'h0;
            next_s.pins.approx_register = {`SCS_NBITS{1'b1}}; // R1 R4
            next_s.pins.msb_inv = 1'b0;
            next_s.pins.busy = 1'b1;
            next_s.pins.bit_clk = 1'b0;
        end

        // Write address and data are taken independently, answered together.
        if (axi_req.awvalid && s.rsp.awready) begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s.rsp.wready) begin
            next_s.w_got = 1'b1;
            next_s.w_data = axi_req.wdata;
            next_s.w_strb = axi_req.wstrb;
        end
        if (s.rsp.bvalid && axi_req.bready) begin
            next_s.rsp.bvalid = 1'b0;
        end
        wr_fire = s.aw_got && s.w_got && !s.rsp.bvalid;
        if (wr_fire) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.rsp.bvalid = 1'b1;
            next_s.rsp.bresp = `SCS_RESP_OKAY;
            case (s.aw_addr)
                `SCS_OFS_CTRL: begin
                    if (s.w_strb[0]) begin
                        next_s.sw_start = s.w_data[`SCS_CTRL_START];
                        next_s.pin_en = s.w_data[`SCS_CTRL_PIN_EN];
                    end
                end
                `SCS_OFS_STATUS: begin
                    if (s.w_strb[0] && s.w_data[`SCS_STATUS_DONE]) begin
                        next_s.done = 1'b0;
                    end
                end
                `SCS_OFS_RESULT: begin
                end
                default: begin
                    next_s.rsp.bresp = `SCS_RESP_SLVERR;
                end
            endcase
        end
        // A completion in the same cycle as a clear keeps the done flag set.
        if (s.state == SCS_CLK_HIGH && next_s.state == SCS_IDLE) begin
            next_s.done = 1'b1;
        end
        next_s.rsp.awready = !next_s.aw_got && !next_s.rsp.bvalid;
        next_s.rsp.wready = !next_s.w_got && !next_s.rsp.bvalid;

        // Read channel: one read at a time, answered the cycle after it is taken.
        if (s.rsp.rvalid && axi_req.rready) begin
            next_s.rsp.rvalid = 1'b0;
        end
        rd_fire = axi_req.arvalid && s.rsp.arready;
        if (rd_fire) begin
            next_s.rsp.rvalid = 1'b1;
            next_s.rsp.rresp = `SCS_RESP_OKAY;
            next_s.rsp.rdata = 32'h00000000;
            case (axi_req.araddr)
                `SCS_OFS_CTRL: begin
                    next_s.rsp.rdata[`SCS_CTRL_PIN_EN] = s.pin_en;
                end
                `SCS_OFS_STATUS: begin
                    next_s.rsp.rdata[`SCS_STATUS_BUSY] = s.pins.busy;
                    next_s.rsp.rdata[`SCS_STATUS_DONE] = s.done;
                    next_s.rsp.rdata[7:4] = s.step;
                end
                `SCS_OFS_RESULT: begin
                    next_s.rsp.rdata[`SCS_NBITS-1:0] = s.result;
                    next_s.rsp.rdata[15:12] = s.result_bits;
                end
                default: begin
                    next_s.rsp.rresp = `SCS_RESP_SLVERR;
                end
            endcase
        end
        next_s.rsp.arready = !next_s.rsp.rvalid;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------

    // Registers the next state; reset parks the sequencer idle with the clock low.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
            s.state <= SCS_IDLE;
            s.pins.approx_register <= {`SCS_NBITS{1'b1}};
            s.pins.serial <= 1'b1;
            s.result <= {`SCS_NBITS{1'b1}};
            s.pin_en <= `SCS_CTRL_PIN_EN_RST;
            s.short_lvl <= 1'b1;
            s.short_sync <= 3'h7;
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from the state register.
    // No output passes through logic after the flops, so pins never glitch.
    assign pins = s.pins; // R14
    assign axi_rsp = s.rsp;

endmodule // scs_sequencer

// File: pkg/scs_map.svh
// Offsets, field positions, reset values and timing counts of the conversion sequencer.
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define SCS_CLK_NS 5
`define SCS_T_HALF_NS 870
`define SCS_T_STATUS_NS 40
`define SCS_T_SERIAL_VALID_NS 200
`define SCS_T_CONV12_US 25
`define SCS_T_CONV10_US 21
`define SCS_T_CONV8_US 17
`define SCS_HALF_CYC (`SCS_T_HALF_NS / `SCS_CLK_NS)
`define SCS_STATUS_CYC ((`SCS_T_STATUS_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)

// ----------------------------------------------------------------------------
// Conversion geometry
// ----------------------------------------------------------------------------
`define SCS_NBITS 12
`define SCS_LAST_STEP 12

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SCS_ADDR_W 8
`define SCS_OFS_CTRL 8'h00
`define SCS_OFS_STATUS 8'h04
`define SCS_OFS_RESULT 8'h08
`define SCS_CTRL_START 0
`define SCS_CTRL_PIN_EN 1
`define SCS_STATUS_BUSY 0
`define SCS_STATUS_DONE 1
`define SCS_CTRL_PIN_EN_RST 1'b1
`define SCS_RESP_OKAY 2'h0
`define SCS_RESP_SLVERR 2'h2

`endif

// File: pkg/scs_pkg.sv
// Types shared by the conversion sequencer and its bench.
`include "scs_map.svh"

package scs_pkg;

    // ------------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCS_IDLE,
        SCS_ARMED,
        SCS_CLK_LOW,
        SCS_CLK_HIGH
    } scs_state_t;

    // ------------------------------------------------------------------------
    // AXI4-Lite carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [`SCS_ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [`SCS_ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } scs_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } scs_axi_rsp_t;

    // ------------------------------------------------------------------------
    // Converter pins driven by the sequencer
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [`SCS_NBITS-1:0] approx_register;
        logic msb_inv;
        logic serial;
        logic bit_clk;
        logic busy;
    } scs_pins_t;

endpackage

// File: test/scs_host_model.sv
// Host side model: comparator source, receiving shift register and latch.
`timescale 1ns/1ps
module scs_host_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Converter pins and the code to present.
    input wire scs_pkg::scs_pins_t pins,
    input wire logic [11:0] target,
    // Comparator drive and captured results.
    output logic comparator,
    output logic [12:0] shifted,
    output logic [11:0] latched
);
    import scs_pkg::*;
    logic prev_clk;
    logic prev_busy;
    logic [3:0] rises;
    // A target bit of one keeps the bit under decision.
    always_comb comparator = (rises >= 4'd1 && rises <= 4'd12) ? target[4'd12 - rises] : 1'b0;
    // Shifts on link clock falls and latches on the busy fall.
    always_ff @(posedge ref_clk) begin
        prev_clk <= pins.bit_clk;
        prev_busy <= pins.busy;
        if (rst || (pins.busy && !prev_busy)) begin
            rises <= 4'h0;
            shifted <= 13'h0;
        end else begin
            if (pins.bit_clk && !prev_clk) rises <= rises + 4'd1;
            if (prev_clk && !pins.bit_clk) shifted <= {shifted[11:0], pins.serial};
            if (prev_busy && !pins.busy) latched <= pins.approx_register;
        end
    end
endmodule // scs_host_model

// File: test/scs_sequencer_assertions.sv
// Checker of the conversion sequencer's pin timing.
`timescale 1ns/1ps
module scs_seq_chk (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Watched ports.
    input wire scs_pkg::scs_axi_req_t axi_req,
    input wire scs_pkg::scs_axi_rsp_t axi_rsp,
    input wire logic convert_start,
    input wire logic comparator,
    input wire logic short_cycle_n,
    input wire scs_pkg::scs_pins_t pins
);
    import scs_pkg::*;
    logic prev_clk;
    logic [3:0] falls;
    logic [9:0] rise_age;
    logic [12:0] busy_age;
    wire clk_fall = prev_clk && !pins.bit_clk;
    wire [3:0] total = falls + {3'h0, clk_fall};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Counts link clock falls, cycles since the last rise and busy time.
    always_ff @(posedge ref_clk) begin
        prev_clk <= rst ? 1'b0 : pins.bit_clk;
        falls <= (rst || !pins.busy) ? 4'h0 : total;
        rise_age <= (pins.bit_clk && !prev_clk) ? 10'h1 : rise_age + {9'h0, rise_age != 10'h3FF};
        busy_age <= (rst || !pins.busy) ? 13'h0 : busy_age + 13'h1;
    end
    a_idle_clk_low: assert property (!pins.busy |-> !pins.bit_clk)
        else $error("Link clock high while idle.");
    a_start_init: assert property ($rose(pins.busy) |-> pins.approx_register == 12'hFFF && !pins.bit_clk)
        else $error("Start did not set all bits.");
    a_first_step: assert property ($rose(pins.bit_clk) && $past(pins.approx_register) == 12'hFFF
        |-> pins.approx_register == 12'h7FF && pins.msb_inv)
        else $error("First step value wrong.");
    a_bit_decide: assert property ($rose(pins.bit_clk) && pins.approx_register != 12'h7FF
        |-> pins.serial == !$past(comparator))
        else $error("Decided bit disagrees with comparator.");
    a_bits_rise: assert property (pins.busy && $past(pins.busy) && !$rose(pins.bit_clk)
        |-> $stable(pins.approx_register) && $stable(pins.serial))
        else $error("Outputs changed off a rising link edge.");
    a_serial_fall: assert property ($fell(pins.bit_clk) |-> $stable(pins.serial))
        else $error("Serial moved at a falling link edge.");
    a_msb_inverse: assert property (pins.msb_inv == !pins.approx_register[11])
        else $error("Inverted top bit wrong.");
    a_busy_delay: assert property ($fell(pins.busy) |-> rise_age == 10'd8)
        else $error("Busy did not end 40 ns after the last decision.");
    a_full_falls: assert property ($fell(pins.busy) && short_cycle_n |-> total == 4'd13)
        else $error("Full conversion falling edge count wrong.");
    a_short_falls: assert property ($fell(pins.busy) && !short_cycle_n
        |-> total == 4'd11 || total == 4'd9)
        else $error("Short conversion falling edge count wrong.");
    a_conv_time: assert property (pins.busy |-> busy_age < 13'd5000)
        else $error("Conversion too long.");
    cover property ($fell(pins.busy) && short_cycle_n);
    cover property ($fell(pins.busy) && !short_cycle_n);
    cover property ($rose(pins.busy));
endmodule // scs_seq_chk

bind scs_sequencer scs_seq_chk scs_seq_chk_i (.ref_clk(ref_clk), .rst(rst), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .convert_start(convert_start), .comparator(comparator),
    .short_cycle_n(short_cycle_n), .pins(pins));

// File: test/tb_top.sv
// Self-checking bench of the conversion sequencer.
`timescale 1ns/1ps
`include "scs_map.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    import scs_pkg::*;
    logic ref_clk, rst, convert_start, short_cycle_n, comparator;
    scs_axi_req_t axi_req;
    scs_axi_rsp_t axi_rsp;
    scs_pins_t pins;
    logic [11:0] target, latched;
    logic [12:0] shifted;
    int mode = 12, fail_count = 0, tests_run = 0, cyc = 0;
    scs_sequencer scs_sequencer_i (.ref_clk(ref_clk), .rst(rst), .axi_req(axi_req),
        .axi_rsp(axi_rsp), .convert_start(convert_start), .comparator(comparator),
        .short_cycle_n(short_cycle_n), .pins(pins));
    scs_host_model scs_host_model_i (.ref_clk(ref_clk), .rst(rst), .pins(pins),
        .target(target), .comparator(comparator), .shifted(shifted), .latched(latched));
    // Makes the 200 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Short-cycle pin follows the bit output wired for the chosen resolution.
    always @(posedge ref_clk) short_cycle_n <= (mode == 12) ? 1'b1 : pins.approx_register[mode == 10 ? 1 : 3];
    // Cuts a hang short.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hF;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (!axi_rsp.bvalid);
        axi_req.bready <= 1'b0;
        `CHK("write response", 2'h0, axi_rsp.bresp)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex,
        input logic [1:0] re, input string nm);
        @(posedge ref_clk);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (!axi_rsp.rvalid);
        axi_req.rready <= 1'b0;
        `CHK(nm, ex, axi_rsp.rdata & m)
        `CHK("read response", re, axi_rsp.rresp)
    endtask
    task automatic pulse;
        @(posedge ref_clk);
        convert_start <= 1'b1;
        repeat (4) @(posedge ref_clk);
        convert_start <= 1'b0;
    endtask
    task automatic conv(input logic [11:0] tg, input int nb, input logic sw);
        logic [11:0] ex;
        int n;
        ex = ~tg;
        for (int i = 0; i < 12 - nb; i++) ex[i] = (i != 11 - nb);
        @(posedge ref_clk);
        target <= tg;
        mode <= nb;
        if (sw) wr(`SCS_OFS_CTRL, 32'h1);
        else pulse();
        n = 0;
        while (!pins.busy && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        while (pins.busy && n < 6000) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK("conversion time", 1'b1, n < (nb == 12 ? 5000 : nb == 10 ? 4200 : 3400))
        repeat (2) @(posedge ref_clk);
        `CHK("latched parallel", ex, latched)
        `CHK("shifted serial", ex >> (12 - nb), shifted[11:0] & (12'hFFF >> (12 - nb)))
        `CHK("inverted top bit", ~ex[11], pins.msb_inv)
        rd(`SCS_OFS_RESULT, 32'hFFFF, {16'h0, nb[3:0], ex}, 2'h0, "result word");
        rd(`SCS_OFS_STATUS, 32'h3, 32'h2, 2'h0, "status done");
        wr(`SCS_OFS_STATUS, 32'h2);
        $display("Test ended: %0d-bit conversion of %h", nb, tg);
    endtask
    // Main sequence.
    initial begin
        rst = 1'b1;
        axi_req = '0;
        convert_start = 1'b0;
        target = 12'h0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        `CHK("idle pins", 16'hFFF4, pins)
        rd(`SCS_OFS_CTRL, 32'hFFFFFFFF, 32'h2, 2'h0, "control reset");
        rd(`SCS_OFS_STATUS, 32'h3, 32'h0, 2'h0, "status reset");
        rd(8'h0C, 32'h0, 32'h0, 2'h2, "unmapped read");
        $display("Test ended: reset and register map");
        conv(12'h676, 12, 1'b0);
        conv(12'h2A5, 10, 1'b0);
        conv(12'hF0F, 8, 1'b0);
        wr(`SCS_OFS_CTRL, 32'h0);
        pulse();
        repeat (20) @(posedge ref_clk);
        `CHK("pin trigger disabled", 1'b0, pins.busy)
        $display("Test ended: pin trigger disabled");
        conv(12'h9C3, 12, 1'b1);
        complete_run();
    end
endmodule // tb_top
